// *** flash_hold_status_pkg.sv ***
// Purpose: shared constants and types for the flash pause and status block
// Assumes: 18-bit array addresses, 8-bit status word
// Notes: register port offsets index 8-bit words
package flash_hold_status_pkg;
   // ---------------------------------------------
   // register port map
   // ---------------------------------------------
   localparam logic [3:0] STATUS_OFFSET = 4'h0;
   localparam logic [3:0] COMMAND_OFFSET = 4'h1;
   localparam int CMD_WRITE_ENABLE_BIT = 0;
   localparam int CMD_WRITE_DISABLE_BIT = 1;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_LATCH_BIT = 1;
   localparam int STATUS_BP_LO_BIT = 2;
   localparam int STATUS_BP_HI_BIT = 3;
   localparam int STATUS_AUTO_INC_BIT = 6;
   localparam int STATUS_LOCK_BIT = 7;
   localparam logic [1:0] PROTECT_RESET = 2'h3;
   localparam logic PROTECT_LOCK_RESET = 1'b0;
   localparam logic [1:0] PROTECT_NONE = 2'h0;
   localparam logic [1:0] PROTECT_QUARTER = 2'h1;
   localparam logic [1:0] PROTECT_HALF = 2'h2;
   localparam logic [1:0] QUARTER_TOP = 2'h3;
   // pins at rest {protect, pause, select, data, clock}: all high but data and clock
   localparam logic [4:0] PIN_IDLE = 5'h1C;

   // ---------------------------------------------
   // types
   // ---------------------------------------------
   typedef struct packed {
      logic protectLock;
      logic autoIncrementProgramMode;
      logic [1:0] reserved;
      logic protectLevelHi;
      logic protectLevelLo;
      logic writeEnableLatch;
      logic busy;
   } status_t;

   typedef enum logic [2:0] {
      OP_BYTE_PROGRAM = 3'h0,
      OP_AUTO_INC_PROGRAM = 3'h1,
      OP_SECTOR_ERASE = 3'h2,
      OP_BLOCK_ERASE = 3'h3,
      OP_CHIP_ERASE = 3'h4
   } op_kind_t;

   typedef struct packed {
      op_kind_t kind;
      logic [17:0] addr;
   } op_req_t;

   typedef enum logic [1:0] {
      LINK_IDLE = 2'b00,
      LINK_ACTIVE = 2'b01,
      LINK_PAUSED = 2'b11
   } link_t;

   // protected range check for a program or erase target
   function automatic logic in_protected(input logic [1:0] level, input logic [17:0] addr);
      unique case (level)
         PROTECT_NONE: in_protected = 1'b0;
         PROTECT_QUARTER: in_protected = (addr[17:16] == QUARTER_TOP);
         PROTECT_HALF: in_protected = addr[17];
         default: in_protected = 1'b1;
      endcase
   endfunction : in_protected
endpackage : flash_hold_status_pkg

// *** flash_hold_and_status_protect.sv ***
// Purpose: serial pause control, write-protect gating and status register of a serial flash
// Assumes: pins are asynchronous to clock and are synchronised here; serial engine and
//          program/erase engine sit outside and use the strobes and grants below
// Notes:
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module flash_hold_and_status_protect (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // serial pins
   input wire logic sckPin,
   input wire logic siPin,
   input wire logic chipSelPinN,
   input wire logic pausePinN,
   input wire logic writeProtectPinN,
   output logic soOut,
   output logic soOe,
   // serial engine side
   input wire logic engineSoData,
   input wire logic engineSoDrive,
   output logic sampleStrobe,
   output logic shiftStrobe,
   output logic siBit,
   output logic paused,
   output logic ifaceReset,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // program and erase engine side
   input wire logic opReq,
   input wire flash_hold_status_pkg::op_req_t opInfo,
   input wire logic opDone,
   input wire logic autoIncrementEnd,
   input wire logic autoIncrementTopReached,
   output logic opGrant,
   output logic opRefuse
);

   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   logic [4:0] syncA_reg;
   logic [4:0] syncB_reg;
   logic sckPrev_reg;
   logic sckS, siS, csS, pauseS, wpS;

   // two flops per pin, first stage read only by the second
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         syncA_reg <= flash_hold_status_pkg::PIN_IDLE;
         syncB_reg <= flash_hold_status_pkg::PIN_IDLE;
         sckPrev_reg <= 1'b0;
      end else begin
         syncA_reg <= {writeProtectPinN, pausePinN, chipSelPinN, siPin, sckPin};
         syncB_reg <= syncA_reg;
         sckPrev_reg <= syncB_reg[0];
      end
   end

   assign sckS = syncB_reg[0];
   assign siS = syncB_reg[1];
   assign csS = syncB_reg[2];
   assign pauseS = syncB_reg[3];
   assign wpS = syncB_reg[4];

   // ---------------------------------------------
   // pause state machine
   // ---------------------------------------------
   flash_hold_status_pkg::link_t link_reg;
   flash_hold_status_pkg::link_t link_next;

   // pause level is only judged while the serial clock is low
   always_comb begin
      link_next = link_reg;
      unique case (link_reg)
         flash_hold_status_pkg::LINK_IDLE: begin
            if (!csS) begin
               link_next = flash_hold_status_pkg::LINK_ACTIVE;
            end
         end
         flash_hold_status_pkg::LINK_ACTIVE: begin
            if (csS) begin
               link_next = flash_hold_status_pkg::LINK_IDLE;
            end else if (!sckS && !pauseS) begin
               link_next = flash_hold_status_pkg::LINK_PAUSED;
            end
         end
         flash_hold_status_pkg::LINK_PAUSED: begin
            if (csS) begin
               link_next = flash_hold_status_pkg::LINK_IDLE;
            end else if (!sckS && pauseS) begin
               link_next = flash_hold_status_pkg::LINK_ACTIVE;
            end
         end
         default: link_next = flash_hold_status_pkg::LINK_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         link_reg <= flash_hold_status_pkg::LINK_IDLE;
      end else begin
         link_reg <= link_next;
      end
   end

   // ---------------------------------------------
   // serial strobes and output pin
   // ---------------------------------------------
   logic linkRun;
   assign linkRun = (link_reg == flash_hold_status_pkg::LINK_ACTIVE) &&
                    (link_next == flash_hold_status_pkg::LINK_ACTIVE);

   // edges are passed on only while running, so a pause freezes the engine
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sampleStrobe <= 1'b0;
         shiftStrobe <= 1'b0;
         siBit <= 1'b0;
         paused <= 1'b0;
         ifaceReset <= 1'b0;
      end else begin
         sampleStrobe <= linkRun && sckS && !sckPrev_reg;
         shiftStrobe <= linkRun && !sckS && sckPrev_reg;
         siBit <= siS;
         paused <= (link_next == flash_hold_status_pkg::LINK_PAUSED);
         ifaceReset <= (link_reg == flash_hold_status_pkg::LINK_PAUSED) && csS;
      end
   end

   // output driver released while paused or deselected
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         soOut <= 1'b0;
         soOe <= 1'b0;
      end else begin
         soOut <= engineSoData;
         soOe <= engineSoDrive && (link_next == flash_hold_status_pkg::LINK_ACTIVE);
      end
   end

   // ---------------------------------------------
   // status register
   // ---------------------------------------------
   // each field is its own flop so that every process owns what it writes
   logic busy_reg;
   logic latch_reg;
   logic levelHi_reg;
   logic levelLo_reg;
   logic lock_reg;
   logic autoInc_reg;
   logic [1:0] level;
   flash_hold_status_pkg::status_t status;
   logic statusWrite, statusAllowed, cmdWrite;
   logic latchSet, latchClear;
   logic reqProtected, reqAllowed;

   // status word assembled from its separately kept fields
   always_comb begin
      status.busy = busy_reg;
      status.writeEnableLatch = latch_reg;
      status.protectLevelLo = levelLo_reg;
      status.protectLevelHi = levelHi_reg;
      status.reserved = 2'h0;
      status.autoIncrementProgramMode = autoInc_reg;
      status.protectLock = lock_reg;
   end

   // protection level as one code for the range checks
   assign level = {levelHi_reg, levelLo_reg};
   assign statusWrite = regWr && (regAddr == flash_hold_status_pkg::STATUS_OFFSET);
   assign cmdWrite = regWr && (regAddr == flash_hold_status_pkg::COMMAND_OFFSET);
   assign statusAllowed = wpS || !lock_reg;
   // chip erase ignores its address and needs the level at none
   assign reqProtected = (opInfo.kind == flash_hold_status_pkg::OP_CHIP_ERASE) ?
                         (level != flash_hold_status_pkg::PROTECT_NONE) :
                         flash_hold_status_pkg::in_protected(level, opInfo.addr);
   // the host is expected to set the latch first; without it the request is refused
   assign reqAllowed = opReq && !busy_reg && latch_reg && !reqProtected;
   // enable command sets the latch when not busy; disable, completions outside auto-increment mode and top reached clear it
   assign latchSet = cmdWrite && regWdata[flash_hold_status_pkg::CMD_WRITE_ENABLE_BIT] && !busy_reg;
   assign latchClear = (cmdWrite && regWdata[flash_hold_status_pkg::CMD_WRITE_DISABLE_BIT]) ||
                       (opDone && !autoInc_reg) || autoIncrementTopReached;

   // protect level and lock, written only through the status write command
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         levelHi_reg <= flash_hold_status_pkg::PROTECT_RESET[1];
         levelLo_reg <= flash_hold_status_pkg::PROTECT_RESET[0];
         lock_reg <= flash_hold_status_pkg::PROTECT_LOCK_RESET;
      end else if (statusWrite && statusAllowed && !busy_reg) begin
         levelHi_reg <= regWdata[flash_hold_status_pkg::STATUS_BP_HI_BIT];
         levelLo_reg <= regWdata[flash_hold_status_pkg::STATUS_BP_LO_BIT];
         lock_reg <= regWdata[flash_hold_status_pkg::STATUS_LOCK_BIT];
      end
   end

   // busy raised on a granted operation, dropped on its completion
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
      end else if (reqAllowed) begin
         busy_reg <= 1'b1;
      end else if (opDone) begin
         busy_reg <= 1'b0;
      end
   end

   // latch: a set in the same cycle as a clear wins
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         latch_reg <= 1'b0;
      end else if (latchSet) begin
         latch_reg <= 1'b1;
      end else if (latchClear) begin
         latch_reg <= 1'b0;
      end
   end

   // auto-increment mode flag, byte mode after reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         autoInc_reg <= 1'b0;
      end else if (reqAllowed && (opInfo.kind == flash_hold_status_pkg::OP_AUTO_INC_PROGRAM)) begin
         autoInc_reg <= 1'b1;
      end else if (autoIncrementEnd || autoIncrementTopReached) begin
         autoInc_reg <= 1'b0;
      end
   end

   // ---------------------------------------------
   // grants and read data
   // ---------------------------------------------
   // grant or refusal answered one cycle after the request
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         opGrant <= 1'b0;
         opRefuse <= 1'b0;
      end else begin
         opGrant <= reqAllowed;
         opRefuse <= opReq && !reqAllowed;
      end
   end

   // read data in the cycle after the strobe only
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         regRdata <= 8'h00;
      end else if (regRd && (regAddr == flash_hold_status_pkg::STATUS_OFFSET)) begin
         regRdata <= status;
      end else begin
         regRdata <= 8'h00;
      end
   end

endmodule : flash_hold_and_status_protect

// *** flash_hold_status_sva.sv ***
// Purpose: port checks for the flash pause and status block
// Assumes: pins pass two sync flops and a state flop
// Notes: bound to the design top
`timescale 1ns/10ps
module flash_hold_status_sva (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // serial side
   input wire logic sckPin,
   input wire logic chipSelPinN,
   input wire logic pausePinN,
   input wire logic engineSoDrive,
   input wire logic soOe,
   input wire logic sampleStrobe,
   input wire logic shiftStrobe,
   input wire logic paused,
   input wire logic ifaceReset,
   // register and op side
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   input wire logic opReq,
   input wire logic opGrant,
   input wire logic opRefuse
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // reads, answers and pause behaviour
   property p_res; regRd |=> regRdata[5:4] == 2'b00; endproperty
   a_res: assert property (p_res) else $error("reserved bits set");
   property p_ack; opReq |=> opGrant != opRefuse; endproperty
   a_ack: assert property (p_ack) else $error("op answer wrong");
   property p_spur; opGrant || opRefuse |-> $past(opReq); endproperty
   a_spur: assert property (p_spur) else $error("op answer unasked");
   property p_strb; paused && $past(paused) |-> !sampleStrobe && !shiftStrobe; endproperty
   a_strb: assert property (p_strb) else $error("strobe while paused");
   property p_soz; paused && $past(paused) |-> !soOe; endproperty
   a_soz: assert property (p_soz) else $error("output driven in pause");
   property p_sod; soOe |-> $past(engineSoDrive); endproperty
   a_sod: assert property (p_sod) else $error("output driven unasked");
   property p_ent; $rose(paused) |-> !$past(chipSelPinN, 3) && !$past(sckPin, 3) && !$past(pausePinN, 3); endproperty
   a_ent: assert property (p_ent) else $error("bad pause entry");
   property p_ext; $fell(paused) |-> $past(chipSelPinN, 3) || $past(pausePinN, 3) && !$past(sckPin, 3); endproperty
   a_ext: assert property (p_ext) else $error("bad pause exit");
   property p_ifr; ifaceReset |-> $past(paused) && !paused; endproperty
   a_ifr: assert property (p_ifr) else $error("bad interface reset");
endmodule : flash_hold_status_sva

bind flash_hold_and_status_protect flash_hold_status_sva u_sva (.clock(clock), .rst_n(rst_n),
   .sckPin(sckPin), .chipSelPinN(chipSelPinN), .pausePinN(pausePinN), .engineSoDrive(engineSoDrive),
   .soOe(soOe), .sampleStrobe(sampleStrobe), .shiftStrobe(shiftStrobe), .paused(paused),
   .ifaceReset(ifaceReset), .regRd(regRd), .regRdata(regRdata), .opReq(opReq), .opGrant(opGrant),
   .opRefuse(opRefuse));

// *** spi_host_model.sv ***
// Purpose: host side of the serial port
// Assumes: 80 ns serial clock, idle low or idle high
// Notes: clock stands still outside frames
`timescale 1ns/10ps
module spi_host_model (
   // requests from the bench
   input wire logic frameOn,
   input wire logic pauseOn,
   input wire logic idleHigh,
   // pins toward the device
   output logic sckPin,
   output logic siPin,
   output logic chipSelPinN,
   output logic pausePinN
);
   // select and pause levels
   assign chipSelPinN = !frameOn;
   assign pausePinN = !pauseOn;
   // clock only inside frames, resting at the chosen idle level
   initial sckPin = 1'b0;
   always #40 sckPin = frameOn ? ~sckPin : idleHigh;
   // data changes after each falling clock
   initial siPin = 1'b0;
   always @(negedge sckPin) siPin <= ~siPin;
endmodule : spi_host_model

// *** test_flash_hold_and_status_protect.sv ***
// Purpose: self-checking bench for the flash pause and status block
// Assumes: status at offset 0, commands at offset 1
// Notes: expectations come from an integer model
`timescale 1ns/10ps
module test_flash_hold_and_status_protect;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic frameOn = 1'b0;
   logic pauseOn = 1'b0;
   logic idleHigh = 1'b0;
   logic sckPin, siPin, chipSelPinN, pausePinN;
   logic writeProtectPinN = 1'b1;
   logic engineSoData = 1'b0;
   logic engineSoDrive = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0, regRd = 1'b0, opReq = 1'b0, opDone = 1'b0;
   logic autoIncrementEnd = 1'b0, autoIncrementTopReached = 1'b0;
   flash_hold_status_pkg::op_req_t opInfo = '0;
   logic soOut, soOe, sampleStrobe, shiftStrobe, siBit, paused, ifaceReset, opGrant, opRefuse;
   logic [7:0] regRdata;
   int bp = 3, lock = 0, latchOn = 0, busy = 0, autoInc = 0;
   int mismatches = 0, checks = 0, seed = 91283;
   int nSample = 0, nShift = 0, nSeen = 0;
   // clock and design
   always #2.5 clock = ~clock;
   always @(posedge clock) engineSoData <= ~engineSoData;
   spi_host_model u_host (.frameOn, .pauseOn, .idleHigh, .sckPin, .siPin, .chipSelPinN, .pausePinN);
   flash_hold_and_status_protect u_dut (.clock, .rst_n, .sckPin, .siPin, .chipSelPinN, .pausePinN,
      .writeProtectPinN, .soOut, .soOe, .engineSoData, .engineSoDrive, .sampleStrobe,
      .shiftStrobe, .siBit, .paused, .ifaceReset, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .opReq, .opInfo, .opDone, .autoIncrementEnd, .autoIncrementTopReached, .opGrant, .opRefuse);
   // strobe counts, sampled data and output copy, watched between clock edges
   always @(negedge clock) begin
      if (sampleStrobe === 1'b1) nSample++;
      if (shiftStrobe === 1'b1) nShift++;
      if (sampleStrobe === 1'b1) chk(8'(siBit), 8'(siPin));
      if (soOe === 1'b1) chk(8'(soOut), 8'(!engineSoData));
   end
   //----------------------------------
   // model and bus tasks
   //----------------------------------
   function automatic logic [7:0] stat();
      stat = {lock[0], autoInc[0], 2'b00, bp[1:0], latchOn[0], busy[0]};
   endfunction : stat
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      if (a == 0 && busy == 0 && !(writeProtectPinN == 0 && lock == 1)) begin
         bp = d[3:2];
         lock = d[7];
      end
      if (a == 1 && busy == 0 && d[0]) latchOn = 1;
      else if (a == 1 && d[1]) latchOn = 0;
      @(posedge clock);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      #1;
      chk(regRdata, e);
   endtask : rd
   task automatic op(input int k, input logic [17:0] ad);
      logic g;
      g = !busy && latchOn && !(bp == 3 || bp == 2 && ad[17] || bp == 1 && ad[17:16] == 2'h3);
      if (k == 4) g = !busy && latchOn && bp == 0;
      @(posedge clock);
      opInfo <= {3'(k), ad};
      opReq <= 1'b1;
      @(posedge clock);
      opReq <= 1'b0;
      #1;
      chk(8'({opGrant, opRefuse}), 8'({g, !g}));
      busy = g;
      if (g && k == 1) autoInc = 1;
   endtask : op
   task automatic fin(input int s);
      @(posedge clock);
      opDone <= s == 0;
      autoIncrementTopReached <= s == 1;
      autoIncrementEnd <= s == 2;
      @(posedge clock);
      {opDone, autoIncrementTopReached, autoIncrementEnd} <= 3'h0;
      if (s == 0) busy = 0;
      if (s == 0 && autoInc == 0 || s == 1) latchOn = 0;
      if (s > 0) autoInc = 0;
   endtask : fin
   task automatic waitp(input logic v);
      for (int n = 0; n < 60 && paused !== v; n++) begin
         @(posedge clock);
         #1;
      end
      chk(8'(paused), 8'(v));
   endtask : waitp
   task print_verdict();
      if (mismatches == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   // watchdog
   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end
   // main sequence
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      rd(0, stat());
      wr(0, 8'hFF);
      rd(0, stat());
      writeProtectPinN <= 1'b0;
      repeat (3) @(posedge clock);
      wr(0, 8'h00);
      rd(0, stat());
      writeProtectPinN <= 1'b1;
      repeat (3) @(posedge clock);
      wr(0, 8'h00);
      rd(0, stat());
      wr(4'h7, 8'hFF);
      rd(4'h7, 8'h00);
      wr(1, 8'h01);
      wr(1, 8'h02);
      rd(0, stat());
      for (int i = 0; i < 24; i++) begin
         wr(0, 8'(i % 4 << 2));
         if (i % 3 != 0) wr(1, 8'h01);
         op($unsigned($random(seed)) % 5, 18'($random(seed)));
         rd(0, stat());
         if (busy) begin
            wr(0, 8'h80);
            wr(1, 8'h01);
            rd(0, stat());
            fin(0);
            if (autoInc) fin(i % 2 + 1);
         end
         rd(0, stat());
      end
      // pause while deselected must not take effect
      pauseOn <= 1'b1;
      repeat (30) @(posedge clock);
      chk(8'(paused), 8'h00);
      pauseOn <= 1'b0;
      frameOn <= 1'b1;
      repeat (40) @(posedge clock);
      #1;
      chk(8'(soOe), 8'h01);
      chk(8'(nSample != 0 && nShift != 0), 8'h01);
      engineSoDrive <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk(8'(soOe), 8'h00);
      engineSoDrive <= 1'b1;
      pauseOn <= 1'b1;
      waitp(1'b1);
      chk(8'(soOe), 8'h00);
      nSeen = nSample + nShift;
      repeat (40) @(posedge clock);
      #1;
      chk(8'(nSample + nShift == nSeen), 8'h01);
      chk(8'(paused), 8'h01);
      pauseOn <= 1'b0;
      waitp(1'b0);
      pauseOn <= 1'b1;
      waitp(1'b1);
      frameOn <= 1'b0;
      for (int n = 0; n < 40 && ifaceReset !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      chk(8'(ifaceReset), 8'h01);
      // second frame with the serial clock resting high
      pauseOn <= 1'b0;
      idleHigh <= 1'b1;
      repeat (30) @(posedge clock);
      nSeen = nSample;
      frameOn <= 1'b1;
      repeat (60) @(posedge clock);
      #1;
      chk(8'(nSample > nSeen), 8'h01);
      frameOn <= 1'b0;
      print_verdict();
   end
endmodule : test_flash_hold_and_status_protect
